//--- hw/slf_pkg.sv
package slf_pkg;

   // The loader runs straight from the crystal with the PLL off.
   localparam int unsigned CLK_HZ        = 10_000_000;
   localparam int          DIV_W         = 16;

   // Character framing on the asynchronous port.
   localparam int          DATA_BITS     = 8;
   localparam int          STOP_BITS     = 1;
   localparam logic [3:0]  FRAME_LAST    = 4'(1 + DATA_BITS + STOP_BITS - 1);
   localparam logic [2:0]  BIT_LAST      = 3'(DATA_BITS - 1);

   // Byte codes of the link.
   localparam logic [7:0]  SYNC_CHAR     = 8'h55;
   localparam logic [7:0]  ACK_BYTE      = 8'hcc;
   localparam logic [7:0]  NAK_BYTE      = 8'h33;
   localparam logic [7:0]  PAD_BYTE      = 8'h00;
   localparam logic [7:0]  PKT_HDR       = 8'h02;

   // Falling edges of one sync character span eight bit times.
   localparam logic [2:0]  MEAS_EDGES    = 3'h5;
   localparam int          MEAS_SHIFT    = 3;

   // Speed limits as fractions of the crystal frequency.
   localparam int          ASYNC_RATIO   = 32;
   localparam int          SYNC_RATIO    = 12;
   localparam int          UART_OVERSMP  = 16;
   localparam int unsigned MAX_BAUD      = CLK_HZ / ASYNC_RATIO;
   localparam int unsigned MAX_SCK_HZ    = CLK_HZ / SYNC_RATIO;
   localparam int          MIN_BIT_CYC   = UART_OVERSMP;

   typedef enum logic [1:0] {LOCK_NONE, LOCK_ASYNC, LOCK_SYNC} slf_lock_t;
   typedef enum logic [2:0] {AB_IDLE, AB_MEAS, AB_CHECK, AB_ACK, AB_DONE} slf_ab_t;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} slf_rx_t;
   typedef enum logic [1:0] {PK_IDLE, PK_SUM, PK_DATA, PK_ANS} slf_pk_t;

endpackage

//--- hw/slf_sync_slave.sv
`timescale 1ns/100ps
`default_nettype none

module slf_sync_slave (
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       sck,
   input  wire logic       fss_n,
   input  wire logic       mosi,
   output logic            miso,
   output logic            miso_oe,
   input  wire logic       drive_en,
   output logic [7:0]      rx_byte,
   output logic            rx_valid,
   input  wire logic [7:0] tx_byte,
   input  wire logic       tx_load,
   output logic            tx_busy
);
   import slf_pkg::*;

   logic [1:0] rst_s_r;
   logic       sck_rst;
   logic [2:0] bit_cnt_r;
   logic [6:0] rx_sh_r;
   logic [7:0] rx_hold_r;
   logic       rx_tog_r;
   logic [1:0] req_s_r;
   logic       ack_tog_r;
   logic [6:0] tx_sh_r;
   logic       miso_r;
   logic [2:0] rx_s_r;
   logic [1:0] ack_s_r;
   logic [1:0] fss_s_r;
   logic       req_tog_r;
   logic [7:0] tx_hold_r;
   logic [7:0] rx_byte_r;
   logic       rx_valid_r;
   logic       oe_r;

   ////////////////////////////////////////////////////////////////////////////
   // The clock may stop between frames, so reset reaches this side only while the host clocks.
   always_ff @(posedge sck) begin
      rst_s_r <= {rst_s_r[0], rst};
   end
   assign sck_rst = rst_s_r[1];

   always_ff @(posedge sck) begin
      if (sck_rst) begin
         bit_cnt_r <= 3'h0;
         rx_sh_r   <= 7'h00;
         rx_hold_r <= 8'h00;
         rx_tog_r  <= 1'b0;
      end else if (!fss_n) begin
         rx_sh_r   <= {rx_sh_r[5:0], mosi};
         bit_cnt_r <= bit_cnt_r + 3'h1;
         if (bit_cnt_r == BIT_LAST) begin
            rx_hold_r <= {rx_sh_r, mosi};
            rx_tog_r  <= ~rx_tog_r;
         end
      end
   end

   always_ff @(negedge sck) begin
      req_s_r <= {req_s_r[0], req_tog_r};
      if (sck_rst) begin
         ack_tog_r <= 1'b0;
         tx_sh_r   <= 7'h00;
         miso_r    <= 1'b1;
      end else if (!fss_n) begin
         if (bit_cnt_r == 3'h0) begin
            if (req_s_r[1] != ack_tog_r) begin
               {miso_r, tx_sh_r} <= tx_hold_r;
               ack_tog_r         <= ~ack_tog_r;
            end else begin
               {miso_r, tx_sh_r} <= PAD_BYTE;
            end
         end else begin
            {miso_r, tx_sh_r} <= {tx_sh_r, 1'b0};
         end
      end
   end
   assign miso = miso_r;

   ////////////////////////////////////////////////////////////////////////////
   // The held byte stays put for eight clocks of the host, far longer than the crossing.
   always_ff @(posedge sys_clk) begin
      rx_s_r  <= {rx_s_r[1:0], rx_tog_r};
      ack_s_r <= {ack_s_r[0], ack_tog_r};
      fss_s_r <= {fss_s_r[0], fss_n};
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rx_valid_r <= 1'b0;
         rx_byte_r  <= 8'h00;
      end else begin
         rx_valid_r <= rx_s_r[1] ^ rx_s_r[2];
         if (rx_s_r[1] ^ rx_s_r[2]) begin
            rx_byte_r <= rx_hold_r;
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         req_tog_r <= 1'b0;
         tx_hold_r <= 8'h00;
      end else if (tx_load && !tx_busy) begin
         tx_hold_r <= tx_byte;
         req_tog_r <= ~req_tog_r;
      end
   end

   // no drive when other port won
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         oe_r <= 1'b0;
      end else begin
         oe_r <= ~fss_s_r[1] & drive_en;
      end
   end

   assign tx_busy  = req_tog_r != ack_s_r[1];
   assign rx_byte  = rx_byte_r;
   assign rx_valid = rx_valid_r;
   assign miso_oe  = oe_r;

endmodule

`default_nettype wire

//--- hw/slf_loader_front.sv
// Operation
// - Once one port is in use, the other is ignored until reset.
// - Both ports feed one packet engine with identical format and answers.
// - Runs on the crystal clock; all speed limits scale with it.
// - Asynchronous characters are eight data bits, no parity, one stop bit.
// - Sync pulses are timed against the clock to set the baud divisor.
// - After successful detection one 0xCC byte goes out at that rate.
// - Synchronous port uses mode with clock idle high, second-edge sampling.
// - Host is synchronous master and clock source; device detects no rate.
// - Each packet is answered with 0xCC if good, 0x33 if faulty.
// - Length byte counts all bytes; checksum is modulo-256 sum of data.
// - Leading zero bytes are skipped; first non-zero byte is meaningful.
`timescale 1ns/100ps
`default_nettype none

module slf_loader_front #(
   parameter int DIV_W = slf_pkg::DIV_W
) (
   input  wire logic        SYS_CLK,
   input  wire logic        RST,
   input  wire logic        UART_RX,
   output logic             UART_TX,
   input  wire logic        SSI_CLK,
   input  wire logic        SSI_FSS_N,
   input  wire logic        SSI_RX,
   output logic             SSI_TX,
   output logic             SSI_TX_OE,
   output logic [7:0]       PKT_DATA,
   output logic             PKT_VALID,
   output logic             PKT_DONE,
   output logic             PKT_GOOD,
   output slf_pkg::slf_lock_t PORT_LOCK,
   output logic [DIV_W-1:0] BAUD_DIV
);
   import slf_pkg::*;

   logic [1:0]       rx_sync_r;
   logic             rx_prev_r;
   logic             rx_line;
   logic             rx_fall;

   slf_ab_t          ab_r;
   logic [DIV_W-1:0] meas_cnt_r;
   logic [2:0]       edge_cnt_r;
   logic [DIV_W-1:0] div_r;
   logic [DIV_W-1:0] meas_bit;

   slf_rx_t          rx_st_r;
   logic [DIV_W-1:0] rx_tmr_r;
   logic [2:0]       rx_bit_r;
   logic [7:0]       rx_sh_r;
   logic [7:0]       rx_byte_r;
   logic             rx_valid_r;
   logic             rx_en;

   logic             tx_busy_r;
   logic [8:0]       tx_sh_r;
   logic [3:0]       tx_cnt_r;
   logic [DIV_W-1:0] tx_tmr_r;
   logic             tx_line_r;
   logic             tx_go;
   logic [7:0]       tx_data;

   slf_lock_t        lock_r;
   slf_lock_t        lock_nxt;

   logic [7:0]       ssi_byte;
   logic             ssi_valid;
   logic             ssi_busy;
   logic             ssi_load;
   logic             ssi_miso;
   logic             ssi_oe;
   logic             ssi_oe_r;

   slf_pk_t          pk_r;
   logic [7:0]       remain_r;
   logic [7:0]       sum_exp_r;
   logic [7:0]       acc_r;
   logic             good_r;
   logic [7:0]       pkt_data_r;
   logic             pkt_valid_r;
   logic             pkt_done_r;
   logic             pkt_good_r;
   logic             in_valid;
   logic [7:0]       in_byte;
   logic             ab_take;
   logic             ans_take;
   logic [7:0]       ans_byte;

   ////////////////////////////////////////////////////////////////////////////
   // Receive pin synchroniser and falling-edge detect.
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         rx_sync_r <= 2'b11;
         rx_prev_r <= 1'b1;
      end else begin
         rx_sync_r <= {rx_sync_r[0], UART_RX};
         rx_prev_r <= rx_sync_r[1];
      end
   end
   assign rx_line  = rx_sync_r[1];
   assign rx_fall  = rx_prev_r & ~rx_line;
   assign meas_bit = meas_cnt_r >> MEAS_SHIFT;

   ////////////////////////////////////////////////////////////////////////////
   // Baud detection. Timing several edges averages out the host's edge jitter.
   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         ab_r       <= AB_IDLE;
         meas_cnt_r <= '0;
         edge_cnt_r <= 3'h0;
         div_r      <= '0;
      end else if (lock_r == LOCK_SYNC) begin
         ab_r <= AB_IDLE;
      end else begin
         unique case (ab_r)
            AB_IDLE: begin
               if (rx_fall) begin
                  meas_cnt_r <= {{(DIV_W-1){1'b0}}, 1'b1};
                  edge_cnt_r <= 3'h1;
                  ab_r       <= AB_MEAS;
               end
            end
            AB_MEAS: begin
               if (&meas_cnt_r) begin
                  ab_r <= AB_IDLE;
               end else begin
                  meas_cnt_r <= meas_cnt_r + 1'b1;
               end
               if (rx_fall) begin
                  if (edge_cnt_r == MEAS_EDGES - 3'h1) begin
                     if (meas_bit < DIV_W'(MIN_BIT_CYC)) begin
                        ab_r <= AB_IDLE;
                     end else begin
                        div_r <= meas_bit;
                        ab_r  <= AB_CHECK;
                     end
                  end else begin
                     edge_cnt_r <= edge_cnt_r + 3'h1;
                  end
               end
            end
            AB_CHECK: begin
               if (rx_valid_r) begin
                  ab_r <= (rx_byte_r == SYNC_CHAR) ? AB_ACK : AB_IDLE;
               end
            end
            AB_ACK: begin
               if (ab_take) begin
                  ab_r <= AB_DONE;
               end
            end
            AB_DONE: begin
               ab_r <= AB_DONE;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Asynchronous receiver, sampling each bit at its middle.
   assign rx_en = (ab_r == AB_CHECK) || (ab_r == AB_DONE);

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         rx_st_r    <= RX_IDLE;
         rx_tmr_r   <= '0;
         rx_bit_r   <= 3'h0;
         rx_sh_r    <= 8'h00;
         rx_byte_r  <= 8'h00;
         rx_valid_r <= 1'b0;
      end else begin
         rx_valid_r <= 1'b0;
         if (rx_st_r == RX_IDLE) begin
            if (rx_en && rx_fall) begin
               rx_tmr_r <= div_r >> 1;
               rx_st_r  <= RX_START;
            end
         end else if (rx_tmr_r != '0) begin
            rx_tmr_r <= rx_tmr_r - 1'b1;
         end else begin
            rx_tmr_r <= div_r - 1'b1;
            unique case (rx_st_r)
               RX_START: begin
                  rx_bit_r <= 3'h0;
                  rx_st_r  <= rx_line ? RX_IDLE : RX_DATA;
               end
               RX_DATA: begin
                  rx_sh_r <= {rx_line, rx_sh_r[7:1]};
                  if (rx_bit_r == BIT_LAST) begin
                     rx_st_r <= RX_STOP;
                  end else begin
                     rx_bit_r <= rx_bit_r + 3'h1;
                  end
               end
               RX_STOP: begin
                  rx_valid_r <= rx_line;
                  rx_byte_r  <= rx_sh_r;
                  rx_st_r    <= RX_IDLE;
               end
               RX_IDLE: begin
                  rx_st_r <= RX_IDLE;
               end
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Asynchronous transmitter at the detected rate.
   // acknowledge at detected rate
   assign ab_take = (ab_r == AB_ACK) && !tx_busy_r;
   assign tx_go   = ab_take || (ans_take && (lock_r == LOCK_ASYNC));
   assign tx_data = ab_take ? ACK_BYTE : ans_byte;

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         tx_busy_r <= 1'b0;
         tx_sh_r   <= 9'h1ff;
         tx_cnt_r  <= 4'h0;
         tx_tmr_r  <= '0;
         tx_line_r <= 1'b1;
      end else if (!tx_busy_r) begin
         if (tx_go) begin
            tx_busy_r <= 1'b1;
            tx_sh_r   <= {1'b1, tx_data};
            tx_cnt_r  <= FRAME_LAST;
            tx_tmr_r  <= div_r - 1'b1;
            tx_line_r <= 1'b0;
         end
      end else if (tx_tmr_r != '0) begin
         tx_tmr_r <= tx_tmr_r - 1'b1;
      end else if (tx_cnt_r == 4'h0) begin
         tx_busy_r <= 1'b0;
      end else begin
         tx_line_r <= tx_sh_r[0];
         tx_sh_r   <= {1'b1, tx_sh_r[8:1]};
         tx_cnt_r  <= tx_cnt_r - 4'h1;
         tx_tmr_r  <= div_r - 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Port arbitration.
   always_comb begin
      lock_nxt = lock_r;
      if (lock_r == LOCK_NONE) begin
         if (ab_r == AB_ACK) begin
            lock_nxt = LOCK_ASYNC;
         end else if (ssi_valid && (ssi_byte != PAD_BYTE)) begin
            lock_nxt = LOCK_SYNC;
         end
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         lock_r <= LOCK_NONE;
      end else begin
         lock_r <= lock_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // host clocks slave port
   slf_sync_slave u_sync (
      .sys_clk  (SYS_CLK),
      .rst      (RST),
      .sck      (SSI_CLK),
      .fss_n    (SSI_FSS_N),
      .mosi     (SSI_RX),
      .miso     (ssi_miso),
      .miso_oe  (ssi_oe),
      .drive_en (lock_r != LOCK_ASYNC),
      .rx_byte  (ssi_byte),
      .rx_valid (ssi_valid),
      .tx_byte  (ans_byte),
      .tx_load  (ssi_load),
      .tx_busy  (ssi_busy)
   );

   assign ssi_load = ans_take && (lock_r == LOCK_SYNC);

   // The slave launches its data from a falling-edge flop, so a further stage would only cost half a bit.
   assign SSI_TX = ssi_miso;

   always_ff @(posedge SYS_CLK) begin
      ssi_oe_r <= RST ? 1'b0 : ssi_oe;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Shared packet engine.
   // one engine for both ports
   assign in_valid = ((lock_r == LOCK_ASYNC) && (ab_r == AB_DONE) && rx_valid_r) ||
                     (ssi_valid && (lock_nxt == LOCK_SYNC));
   assign in_byte  = (lock_r == LOCK_ASYNC) ? rx_byte_r : ssi_byte;
   assign ans_byte = good_r ? ACK_BYTE : NAK_BYTE;
   assign ans_take = (pk_r == PK_ANS) &&
                     ((lock_r == LOCK_ASYNC) ? !tx_busy_r : !ssi_busy);

   always_ff @(posedge SYS_CLK) begin
      if (RST) begin
         pk_r        <= PK_IDLE;
         remain_r    <= 8'h00;
         sum_exp_r   <= 8'h00;
         acc_r       <= 8'h00;
         good_r      <= 1'b0;
         pkt_data_r  <= 8'h00;
         pkt_valid_r <= 1'b0;
         pkt_done_r  <= 1'b0;
         pkt_good_r  <= 1'b0;
      end else begin
         pkt_valid_r <= 1'b0;
         pkt_done_r  <= 1'b0;
         unique case (pk_r)
            PK_IDLE: begin
               if (in_valid && (in_byte != PAD_BYTE)) begin
                  remain_r <= in_byte - PKT_HDR;
                  acc_r    <= 8'h00;
                  if (in_byte < PKT_HDR) begin
                     good_r <= 1'b0;
                     pk_r   <= PK_ANS;
                  end else begin
                     pk_r <= PK_SUM;
                  end
               end
            end
            PK_SUM: begin
               if (in_valid) begin
                  sum_exp_r <= in_byte;
                  if (remain_r == 8'h00) begin
                     good_r <= (in_byte == 8'h00);
                     pk_r   <= PK_ANS;
                  end else begin
                     pk_r <= PK_DATA;
                  end
               end
            end
            PK_DATA: begin
               if (in_valid) begin
                  acc_r       <= acc_r + in_byte;
                  pkt_data_r  <= in_byte;
                  pkt_valid_r <= 1'b1;
                  remain_r    <= remain_r - 8'h01;
                  if (remain_r == 8'h01) begin
                     good_r <= ((acc_r + in_byte) == sum_exp_r);
                     pk_r   <= PK_ANS;
                  end
               end
            end
            PK_ANS: begin
               if (ans_take) begin
                  pkt_done_r <= 1'b1;
                  pkt_good_r <= good_r;
                  pk_r       <= PK_IDLE;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign UART_TX   = tx_line_r;
   assign SSI_TX_OE = ssi_oe_r;
   assign PKT_DATA  = pkt_data_r;
   assign PKT_VALID = pkt_valid_r;
   assign PKT_DONE  = pkt_done_r;
   assign PKT_GOOD  = pkt_good_r;
   assign PORT_LOCK = lock_r;
   assign BAUD_DIV  = div_r;

endmodule

`default_nettype wire

//--- verification/slf_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module slf_host_model (
   input  wire logic sys_clk,
   output logic      uart_rx,
   input  wire logic uart_tx,
   output logic      ssi_clk,
   output logic      ssi_fss_n,
   output logic      ssi_rx,
   input  wire logic ssi_tx,
   input  wire logic ssi_tx_oe
);
   logic last_r = 1'b0;
   logic miso_w;
   initial begin
      uart_rx = 1'b1;
      ssi_clk = 1'b1;
      ssi_fss_n = 1'b1;
      ssi_rx = 1'b1;
   end
   assign miso_w = ssi_tx_oe ? ssi_tx : ~last_r;
   always @(posedge ssi_clk) last_r <= miso_w;
   ////////////////////////////////////////////////////////////////////////////
   // Eight-N-one frames.
   task automatic uart_put(input logic [7:0] b, input int div);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge sys_clk);
         uart_rx <= f[i];
         repeat (div - 1) @(posedge sys_clk);
      end
   endtask
   task automatic uart_get(input int div, output logic [7:0] b);
      int n;
      b = 8'hxx;
      n = 0;
      while (uart_tx === 1'b1 && n < 80 * div) begin
         @(posedge sys_clk);
         n++;
      end
      if (n < 80 * div) begin
         repeat (div / 2) @(posedge sys_clk);
         for (int i = 0; i < 8; i++) begin
            repeat (div) @(posedge sys_clk);
            b[i] = uart_tx;
         end
         repeat (div) @(posedge sys_clk);
         if (uart_tx !== 1'b1) b = 8'hxx;
      end
   endtask
   task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
      #13;
      ssi_fss_n = 1'b0;
      #500;
      for (int i = 7; i >= 0; i--) begin
         ssi_clk = 1'b0;
         ssi_rx = tx[i];
         #40;
         ssi_clk = 1'b1;
         rx[i] = miso_w;
         #40;
      end
      ssi_fss_n = 1'b1;
      ssi_rx = ~ssi_rx;
      #1000;
   endtask
   // Clock runs only while reset needs it.
   task automatic sck_pulses(input int n);
      repeat (n) begin
         #40 ssi_clk = 1'b0;
         #40 ssi_clk = 1'b1;
      end
   endtask
endmodule
`default_nettype wire

//--- verification/slf_loader_front_chk.sv
`timescale 1ns/100ps
`default_nettype none
module slf_loader_front_chk #(
   parameter int DIV_W = 16
) (
   input wire logic               SYS_CLK,
   input wire logic               RST,
   input wire logic               UART_RX,
   input wire logic               UART_TX,
   input wire logic               SSI_CLK,
   input wire logic               SSI_FSS_N,
   input wire logic               SSI_RX,
   input wire logic               SSI_TX,
   input wire logic               SSI_TX_OE,
   input wire logic [7:0]         PKT_DATA,
   input wire logic               PKT_VALID,
   input wire logic               PKT_DONE,
   input wire logic               PKT_GOOD,
   input wire slf_pkg::slf_lock_t PORT_LOCK,
   input wire logic [DIV_W-1:0]   BAUD_DIV
);
   import slf_pkg::*;
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (RST);
   // The answer frame starts in the same cycle as PKT_DONE, as the engine only answers once the line is free; the slack is spare.
   sequence answer_out_s;
      ##[0:8] !UART_TX;
   endsequence
   lock_hold_a: assert property (PORT_LOCK != LOCK_NONE |=> PORT_LOCK == $past(PORT_LOCK))
      else $error("port lock changed");
   sync_quiet_a: assert property (PORT_LOCK == LOCK_SYNC |-> UART_TX)
      else $error("async line active under sync lock");
   oe_async_a: assert property (PORT_LOCK == LOCK_ASYNC && $past(PORT_LOCK, 2) == LOCK_ASYNC |-> !SSI_TX_OE)
      else $error("sync output driven under async lock");
   div_hold_a: assert property (PORT_LOCK == LOCK_ASYNC |=> $stable(BAUD_DIV))
      else $error("baud divisor moved");
   div_min_a: assert property (BAUD_DIV != 0 |-> BAUD_DIV >= 16)
      else $error("baud divisor too small");
   sync_ack_a: assert property ($rose(PORT_LOCK == LOCK_ASYNC) |-> ##[0:3] !UART_TX)
      else $error("no acknowledge frame after detection");
   oe_idle_a: assert property (SSI_FSS_N [*5] |-> !SSI_TX_OE)
      else $error("sync output driven while deselected");
   oe_frame_a: assert property ((!SSI_FSS_N && PORT_LOCK != LOCK_ASYNC) [*5] |-> SSI_TX_OE)
      else $error("sync output released while selected");
   answer_a: assert property (PKT_DONE && PORT_LOCK == LOCK_ASYNC |-> answer_out_s)
      else $error("packet answer frame missing");
   good_hold_a: assert property (!PKT_DONE |-> $stable(PKT_GOOD))
      else $error("packet status moved without answer");
   valid_pulse_a: assert property (PKT_VALID |=> !PKT_VALID)
      else $error("data strobe longer than one cycle");
endmodule
bind slf_loader_front slf_loader_front_chk #(.DIV_W(DIV_W)) i_chk (
   .SYS_CLK(SYS_CLK), .RST(RST), .UART_RX(UART_RX), .UART_TX(UART_TX), .SSI_CLK(SSI_CLK),
   .SSI_FSS_N(SSI_FSS_N), .SSI_RX(SSI_RX), .SSI_TX(SSI_TX), .SSI_TX_OE(SSI_TX_OE), .PKT_DATA(PKT_DATA),
   .PKT_VALID(PKT_VALID), .PKT_DONE(PKT_DONE), .PKT_GOOD(PKT_GOOD), .PORT_LOCK(PORT_LOCK), .BAUD_DIV(BAUD_DIV)
);
`default_nettype wire

//--- verification/slf_loader_front_tb.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin bad_count++; $display("MISMATCH %s exp %h got %h", nm, ex, got); end end
module slf_loader_front_tb;
   import slf_pkg::*;
   localparam int BIT_CYC = 32;
   logic       sys_clk = 1'b0;
   logic       rst = 1'b1;
   wire logic  uart_rx, ssi_clk, ssi_fss_n, ssi_rx;
   logic       uart_tx, ssi_tx, ssi_tx_oe, pkt_valid, pkt_done, pkt_good;
   logic [7:0] pkt_data;
   logic [15:0] baud_div;
   slf_lock_t  port_lock;
   logic [7:0] last_data = 8'h00;
   int         bad_count = 0;
   int         n_compared = 0;
   always #50 sys_clk = ~sys_clk;
   slf_loader_front i_dut (.SYS_CLK(sys_clk), .RST(rst), .UART_RX(uart_rx), .UART_TX(uart_tx), .SSI_CLK(ssi_clk),
      .SSI_FSS_N(ssi_fss_n), .SSI_RX(ssi_rx), .SSI_TX(ssi_tx), .SSI_TX_OE(ssi_tx_oe), .PKT_DATA(pkt_data),
      .PKT_VALID(pkt_valid), .PKT_DONE(pkt_done), .PKT_GOOD(pkt_good), .PORT_LOCK(port_lock), .BAUD_DIV(baud_div));
   slf_host_model i_host (.sys_clk(sys_clk), .uart_rx(uart_rx), .uart_tx(uart_tx), .ssi_clk(ssi_clk),
      .ssi_fss_n(ssi_fss_n), .ssi_rx(ssi_rx), .ssi_tx(ssi_tx), .ssi_tx_oe(ssi_tx_oe));
   always @(posedge sys_clk) begin
      if (pkt_valid === 1'b1) last_data <= pkt_data;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Link-side counters only clear while the link clock moves.
   task automatic do_reset();
      rst <= 1'b1;
      fork
         repeat (12) @(posedge sys_clk);
         i_host.sck_pulses(4);
      join
      rst <= 1'b0;
      // The link side leaves reset only on link clock edges after release.
      i_host.sck_pulses(4);
      @(posedge sys_clk);
      `CHK("uart_tx", 1'b1, uart_tx)
      `CHK("oe", 1'b0, ssi_tx_oe)
      `CHK("lock", LOCK_NONE, port_lock)
      `CHK("div", 16'h0000, baud_div)
      $display("reset done");
   endtask
   task automatic test_autobaud();
      logic [7:0] b;
      fork
         begin
            i_host.uart_put(SYNC_CHAR, BIT_CYC);
            i_host.uart_put(SYNC_CHAR, BIT_CYC);
         end
         i_host.uart_get(BIT_CYC, b);
      join
      `CHK("div", 16'(BIT_CYC), baud_div)
      `CHK("ack", ACK_BYTE, b)
      `CHK("lock", LOCK_ASYNC, port_lock)
      $display("autobaud done");
   endtask
   // Same bytes on either port, with a leading pad byte.
   task automatic send_pkt(input logic spi, input logic [7:0] sum, input logic [7:0] ans);
      logic [7:0] p [4];
      logic [7:0] b;
      p = '{PAD_BYTE, 8'h03, sum, 8'h20};
      b = PAD_BYTE;
      if (spi) begin
         for (int i = 0; i < 4; i++)
            i_host.spi_byte(p[i], b);
         for (int i = 0; i < 8 && b === PAD_BYTE; i++)
            i_host.spi_byte(PAD_BYTE, b);
      end else begin
         fork
            for (int i = 0; i < 4; i++)
               i_host.uart_put(p[i], BIT_CYC);
            i_host.uart_get(BIT_CYC, b);
         join
      end
      `CHK("answer", ans, b)
      `CHK("good", ans == ACK_BYTE, pkt_good)
      `CHK("data", 8'h20, last_data)
      $display("packet done");
   endtask
   // A stray length byte on the sync port must not upset async framing.
   task automatic test_async_lock();
      logic [7:0] b;
      i_host.spi_byte(8'h03, b);
      `CHK("lock", LOCK_ASYNC, port_lock)
      send_pkt(1'b0, 8'h21, NAK_BYTE);
      $display("async lock done");
   endtask
   task automatic test_sync_lock();
      send_pkt(1'b1, 8'h20, ACK_BYTE);
      `CHK("lock", LOCK_SYNC, port_lock)
      i_host.uart_put(SYNC_CHAR, BIT_CYC);
      i_host.uart_put(SYNC_CHAR, BIT_CYC);
      repeat (40 * BIT_CYC) @(posedge sys_clk);
      `CHK("div", 16'h0000, baud_div)
      `CHK("lock", LOCK_SYNC, port_lock)
      send_pkt(1'b1, 8'h21, NAK_BYTE);
      $display("sync lock done");
   endtask
   initial begin
      do_reset();
      test_autobaud();
      send_pkt(1'b0, 8'h20, ACK_BYTE);
      test_async_lock();
      do_reset();
      test_sync_lock();
      end_of_test();
   end
   // The whole sequence needs well under ten thousand cycles.
   initial begin
      repeat (30000) @(posedge sys_clk);
      bad_count++;
      end_of_test();
   end
endmodule
`default_nettype wire
